// file: src/acpc_control.sv
`timescale 1ns/100ps
module acpc_control (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic [1:0] shutdown_pin,
	input wire logic [11:0] analog_code,
	output logic dout,
	output logic dout_oe_n,
	output logic conversion_strobe,
	output logic strobe_oe_n,
	output logic hw_power_down,
	output logic sw_power_down,
	output logic ext_clock_mode,
	output logic converting
);
	// ****************************************************************
	// Pin synchronisers and serial clock edges
	// ****************************************************************
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;
	logic sclk_prev;
	logic sclk_s;
	logic cs_n_s;
	logic din_s;
	logic [1:0] shutdown_pin_s;
	logic sclk_rise;
	logic sclk_fall;
	logic selected;

	// Multi-bit shutdown code is a slow static level, so plain double flopping is enough.
	// Reset shows an idle link and shutdown high, so no false edge or power-down follows.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta <= {acpc_pkg::SHUTDOWN_PIN_HIGH, 3'h2};
			pin_sync <= {acpc_pkg::SHUTDOWN_PIN_HIGH, 3'h2};
			sclk_prev <= 1'b0;
		end else begin
			pin_meta <= {shutdown_pin, din, cs_n, sclk};
			pin_sync <= pin_meta;
			sclk_prev <= pin_sync[0];
		end
	end

	assign sclk_s = pin_sync[0];
	assign cs_n_s = pin_sync[1];
	assign din_s = pin_sync[2];
	assign shutdown_pin_s = pin_sync[4:3];
	assign sclk_rise = sclk_s && !sclk_prev;
	assign sclk_fall = !sclk_s && sclk_prev;
	assign selected = !cs_n_s;

	// ****************************************************************
	// Result buffer
	// ****************************************************************
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [11:0] fifo_out_data;
	logic [11:0] result;

	acpc_fifo #(
		.WIDTH(acpc_pkg::RESULT_BITS),
		.DEPTH(acpc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(result),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// ****************************************************************
	// Conversion sequencer
	// ****************************************************************
	acpc_pkg::acpc_state_t state;
	acpc_pkg::acpc_state_t next_state;
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [3:0] bit_idx;
	logic [3:0] next_bit_idx;
	logic [11:0] next_result;
	logic [11:0] shreg;
	logic [11:0] next_shreg;
	logic [10:0] div_cnt;
	logic [10:0] next_div_cnt;
	logic [3:0] step;
	logic [3:0] next_step;
	logic pd_pending;
	logic next_pd_pending;
	logic next_dout;
	logic next_dout_oe_n;
	logic next_strobe;
	logic next_strobe_oe_n;
	logic next_hw_pd;
	logic next_sw_pd;
	logic next_ext_mode;
	logic next_converting;
	logic start_ok;
	logic conv_tick;

	always_comb begin
		next_state = state;
		next_ctrl = ctrl;
		next_bit_idx = bit_idx;
		next_result = result;
		next_shreg = shreg;
		next_div_cnt = '0;
		next_step = step;
		next_pd_pending = pd_pending;
		next_dout = dout;
		next_strobe = conversion_strobe;
		next_sw_pd = sw_power_down;
		next_ext_mode = ext_clock_mode;
		fifo_in_valid = 1'b0;
		fifo_out_ready = 1'b0;
		conv_tick = 1'b0;
		// A start bit is honoured only when idle or once bit 6 of the result has gone out.
		// A finished internal result only waits to be read, so the converter is idle there
		// and unread results stay queued in the buffer.
		start_ok = selected && sclk_rise && din_s && ((state == acpc_pkg::ST_IDLE)
			|| (state == acpc_pkg::ST_INT_OUT)
			|| (state == acpc_pkg::ST_EXT_SHIFT
			&& bit_idx > acpc_pkg::START_WINDOW_BIT));
		if (state == acpc_pkg::ST_INT_CONV) begin
			// Divider period follows the shutdown level.
			if (div_cnt == ((shutdown_pin_s == acpc_pkg::SHUTDOWN_PIN_FLOAT) ? acpc_pkg::DIV_FLOAT
				: acpc_pkg::DIV_HIGH) - 11'h001) begin
				conv_tick = 1'b1;
			end else begin
				next_div_cnt = div_cnt + 11'h001;
			end
		end
		if (shutdown_pin_s == acpc_pkg::SHUTDOWN_PIN_LOW) begin
			// Hardware shutdown wins over everything and discards the conversion.
			next_state = acpc_pkg::ST_IDLE;
			next_bit_idx = '0;
			next_step = '0;
			next_dout = 1'b0;
			next_pd_pending = 1'b0;
		end else if (start_ok) begin
			next_state = acpc_pkg::ST_CTRL;
			next_ctrl = 8'h01;
			next_bit_idx = 4'h1;
			next_sw_pd = 1'b0;
		end else begin
			unique case (state)
				acpc_pkg::ST_IDLE: begin
					next_dout = 1'b0;
				end
				acpc_pkg::ST_CTRL: begin
					if (sclk_rise && selected && bit_idx < acpc_pkg::CTRL_BITS) begin
						next_ctrl = {ctrl[6:0], din_s};
						next_bit_idx = bit_idx + 4'h1;
					end else if (sclk_fall && bit_idx == acpc_pkg::CTRL_BITS) begin
						next_result = analog_code;
						next_bit_idx = '0;
						next_step = '0;
						// Power-down and unassigned codes keep the last clock mode.
						unique case (ctrl[1:0])
							acpc_pkg::MODE_EXT: next_ext_mode = 1'b1;
							acpc_pkg::MODE_INT: next_ext_mode = 1'b0;
							acpc_pkg::MODE_UNASSIGNED: next_ext_mode = ext_clock_mode;
							acpc_pkg::MODE_POWER_DOWN: next_ext_mode = ext_clock_mode;
						endcase
						next_pd_pending = (ctrl[1:0] == acpc_pkg::MODE_POWER_DOWN);
						if (ctrl[1:0] == acpc_pkg::MODE_EXT || (!ctrl[1] && ext_clock_mode)) begin
							next_state = acpc_pkg::ST_EXT_STROBE;
							next_strobe = 1'b1;
						end else begin
							next_state = acpc_pkg::ST_INT_CONV;
							next_strobe = 1'b0;
						end
					end
				end
				acpc_pkg::ST_EXT_STROBE: begin
					if (sclk_fall) begin
						next_strobe = 1'b0;
						next_dout = result[11];
						next_bit_idx = 4'h1;
						next_state = acpc_pkg::ST_EXT_SHIFT;
					end
				end
				acpc_pkg::ST_EXT_SHIFT: begin
					if (sclk_fall) begin
						next_dout = (bit_idx <= acpc_pkg::LAST_RESULT_BIT)
							? result[acpc_pkg::LAST_RESULT_BIT - bit_idx] : 1'b0;
						next_bit_idx = bit_idx + 4'h1;
						if (bit_idx == acpc_pkg::LAST_RESULT_BIT) begin
							next_sw_pd = pd_pending;
						end
						if (bit_idx == acpc_pkg::LAST_READ_BIT) begin
							next_state = acpc_pkg::ST_IDLE;
						end
					end
				end
				acpc_pkg::ST_INT_CONV: begin
					next_div_cnt = conv_tick ? 11'h000 : next_div_cnt;
					if (conv_tick) begin
						next_step = step + 4'h1;
						if (step == acpc_pkg::CONV_STEPS - 4'h1) begin
							next_state = acpc_pkg::ST_INT_DONE;
						end
					end
				end
				acpc_pkg::ST_INT_DONE: begin
					// A full result buffer holds the strobe low; nothing is read here, so only hardware shutdown ends the wait.
					fifo_in_valid = 1'b1;
					if (fifo_in_ready) begin
						next_strobe = 1'b1;
						next_sw_pd = pd_pending;
						next_bit_idx = '0;
						next_state = acpc_pkg::ST_INT_OUT;
					end
				end
				acpc_pkg::ST_INT_OUT: begin
					if (sclk_fall) begin
						if (bit_idx == 4'h0) begin
							fifo_out_ready = 1'b1;
							next_shreg = {fifo_out_data[10:0], 1'b0};
							next_dout = fifo_out_data[11];
						end else begin
							next_shreg = {shreg[10:0], 1'b0};
							next_dout = shreg[11];
						end
						next_bit_idx = bit_idx + 4'h1;
						if (bit_idx == acpc_pkg::LAST_READ_BIT) begin
							next_state = acpc_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					next_state = acpc_pkg::ST_IDLE;
				end
			endcase
		end
		next_hw_pd = (shutdown_pin_s == acpc_pkg::SHUTDOWN_PIN_LOW);
		next_dout_oe_n = !selected;
		// The strobe only floats with chip select high in external clock mode.
		next_strobe_oe_n = !selected && next_ext_mode;
		next_converting = (next_state == acpc_pkg::ST_EXT_STROBE)
			|| (next_state == acpc_pkg::ST_EXT_SHIFT && next_bit_idx <= acpc_pkg::LAST_RESULT_BIT)
			|| (next_state == acpc_pkg::ST_INT_CONV) || (next_state == acpc_pkg::ST_INT_DONE);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= acpc_pkg::ST_IDLE;
			ctrl <= '0;
			bit_idx <= '0;
			result <= '0;
			shreg <= '0;
			div_cnt <= '0;
			step <= '0;
			pd_pending <= 1'b0;
			dout <= 1'b0;
			dout_oe_n <= 1'b1;
			conversion_strobe <= acpc_pkg::RESET_STROBE;
			strobe_oe_n <= 1'b0;
			hw_power_down <= 1'b0;
			sw_power_down <= 1'b0;
			ext_clock_mode <= acpc_pkg::RESET_EXT_MODE;
			converting <= 1'b0;
		end else begin
			state <= next_state;
			ctrl <= next_ctrl;
			bit_idx <= next_bit_idx;
			result <= next_result;
			shreg <= next_shreg;
			div_cnt <= next_div_cnt;
			step <= next_step;
			pd_pending <= next_pd_pending;
			dout <= next_dout;
			dout_oe_n <= next_dout_oe_n;
			conversion_strobe <= next_strobe;
			strobe_oe_n <= next_strobe_oe_n;
			hw_power_down <= next_hw_pd;
			sw_power_down <= next_sw_pd;
			ext_clock_mode <= next_ext_mode;
			converting <= next_converting;
		end
	end
endmodule : acpc_control

// file: src/acpc_pkg.sv
package acpc_pkg;
	// ****************************************************************
	// Clock and conversion clock rates
	// ****************************************************************
	localparam int CLK_HZ = 250_000_000;
	localparam int CONV_HZ_HIGH = 225_000;
	localparam int CONV_HZ_FLOAT = 1_800_000;
	localparam logic [10:0] DIV_HIGH = 11'(CLK_HZ / CONV_HZ_HIGH);
	localparam logic [10:0] DIV_FLOAT = 11'(CLK_HZ / CONV_HZ_FLOAT);

	// ****************************************************************
	// Control byte and result framing
	// ****************************************************************
	localparam logic [1:0] MODE_EXT = 2'h3;
	localparam logic [1:0] MODE_INT = 2'h2;
	localparam logic [1:0] MODE_UNASSIGNED = 2'h1;
	localparam logic [1:0] MODE_POWER_DOWN = 2'h0;
	localparam int RESULT_BITS = 12;
	localparam int CODE_STEPS = 4096;
	localparam logic [3:0] CTRL_BITS = 4'h8;
	localparam logic [3:0] LAST_READ_BIT = 4'hf;
	localparam logic [3:0] LAST_RESULT_BIT = 4'hb;
	localparam logic [3:0] START_WINDOW_BIT = 4'h5;
	localparam logic [3:0] CONV_STEPS = 4'hc;
	localparam int FIFO_DEPTH = 8;

	// ****************************************************************
	// Decoded shutdown pin levels
	// ****************************************************************
	localparam logic [1:0] SHUTDOWN_PIN_LOW = 2'h0;
	localparam logic [1:0] SHUTDOWN_PIN_HIGH = 2'h1;
	localparam logic [1:0] SHUTDOWN_PIN_FLOAT = 2'h2;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic RESET_EXT_MODE = 1'b0;
	localparam logic RESET_STROBE = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CTRL = 3'b001,
		ST_EXT_STROBE = 3'b010,
		ST_EXT_SHIFT = 3'b011,
		ST_INT_CONV = 3'b100,
		ST_INT_DONE = 3'b101,
		ST_INT_OUT = 3'b110
	} acpc_state_t;
endpackage : acpc_pkg

// file: src/acpc_fifo.sv
`timescale 1ns/100ps
module acpc_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// The storage has no reset; only the pointers and the count say what is valid.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule : acpc_fifo

// file: tb/acpc_checker.sv
`timescale 1ns/100ps
module acpc_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [1:0] shutdown_pin,
	input wire logic conversion_strobe,
	input wire logic strobe_oe_n,
	input wire logic hw_power_down,
	input wire logic sw_power_down,
	input wire logic ext_clock_mode,
	input wire logic converting
);
	// ****************************************************************
	// Strobe low-time counter
	// ****************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [15:0] low_cnt;
	logic [15:0] next_low_cnt;
	always_comb begin
		next_low_cnt = low_cnt;
		if (conversion_strobe)
			next_low_cnt = 16'h0;
		else if (low_cnt != 16'hffff)
			next_low_cnt = low_cnt + 16'h1;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			low_cnt <= 16'h0;
		else
			low_cnt <= next_low_cnt;
	end
	sequence s_int_start;
		$fell(conversion_strobe) && !ext_clock_mode;
	endsequence
	sequence s_ext_pulse;
		$rose(conversion_strobe) && ext_clock_mode;
	endsequence
	sequence s_int_done;
		$rose(conversion_strobe) && !ext_clock_mode && !hw_power_down &&
			!$past(hw_power_down) && !$past(hw_power_down, 2);
	endsequence
	// ****************************************************************
	// Assertions
	// ****************************************************************
	AST_HW_PD_SET: assert property ((shutdown_pin == acpc_pkg::SHUTDOWN_PIN_LOW) [*6] |-> hw_power_down)
		else $error("hardware power down not entered");
	AST_HW_PD_CLR: assert property ((shutdown_pin != acpc_pkg::SHUTDOWN_PIN_LOW) [*6] |-> !hw_power_down)
		else $error("hardware power down held while enabled");
	AST_ABORT: assert property (hw_power_down [*2] |-> !converting)
		else $error("conversion runs in hardware power down");
	AST_INT_START: assert property (s_int_start |-> ##[0:2] converting)
		else $error("strobe fell without conversion");
	// The divider restarts from zero for each conversion, so the first tick is whole; one tick is still allowed.
	AST_INT_TIME: assert property (s_int_done |-> low_cnt >= 16'h05ee)
		else $error("internal conversion too short");
	AST_EXT_PULSE: assert property (s_ext_pulse |-> conversion_strobe [*5])
		else $error("external strobe pulse too short");
	AST_WAKE: assert property ($rose(converting) |-> !sw_power_down)
		else $error("conversion started in software power down");
	AST_STROBE_DRIVE: assert property (!ext_clock_mode [*3] |-> !strobe_oe_n)
		else $error("strobe released in internal mode");
endmodule : acpc_checker

// file: tb/acpc_host_model.sv
`timescale 1ns/100ps
module acpc_host_model (
	input wire logic clk,
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	input wire logic conversion_strobe
);
	// ****************************************************************
	// Serial host, clock idle low, data changed on the falling edge
	// ****************************************************************
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	task automatic half;
		repeat (4) @(posedge clk);
	endtask : half
	task automatic tick(input logic b, output logic q);
		din <= b;
		half();
		sclk <= 1'b1;
		q = dout;
		half();
		sclk <= 1'b0;
	endtask : tick
	// The clock stands still while the strobe is awaited, as an internal
	// conversion wants a quiet clock.
	task automatic frame(input logic [7:0] ctrl, input logic rd, output logic [15:0] rx);
		logic q;
		int n;
		n = 0;
		rx = 16'h0;
		cs_n <= 1'b0;
		half();
		for (int i = 7; i >= 0; i--) begin
			tick(ctrl[i], q);
		end
		repeat (3) half();
		while (conversion_strobe !== 1'b1 && n < 16000) begin
			@(posedge clk);
			n++;
		end
		for (int i = 0; i < 17 && rd; i++) begin
			tick(1'b0, q);
			if (i > 0)
				rx = {rx[14:0], q};
		end
		half();
		cs_n <= 1'b1;
		half();
	endtask : frame
endmodule : acpc_host_model

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
	logic clk;
	logic reset_n;
	logic [1:0] shutdown_pin;
	logic [11:0] analog_code;
	logic sclk, cs_n, din, dout, dout_oe_n, conversion_strobe, strobe_oe_n;
	logic hw_power_down, sw_power_down, ext_clock_mode, converting;
	logic [15:0] rx;
	int n_errors = 0;
	int compares = 0;

	acpc_control dut (.clk, .reset_n, .sclk, .cs_n, .din, .shutdown_pin, .analog_code, .dout,
		.dout_oe_n, .conversion_strobe, .strobe_oe_n, .hw_power_down, .sw_power_down,
		.ext_clock_mode, .converting);
	acpc_host_model host (.clk, .sclk, .cs_n, .din, .dout, .conversion_strobe);

	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done;
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task automatic conv(input logic [7:0] ctrl, input logic [11:0] code);
		analog_code <= code;
		host.frame(ctrl, 1'b1, rx);
		check("result", rx, {code, 4'h0});
		check("dout release", dout_oe_n, 16'h1);
	endtask : conv

	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (95000) @(posedge clk);
		n_errors++;
		test_done();
	end
	initial begin
		reset_n = 1'b0;
		shutdown_pin = acpc_pkg::SHUTDOWN_PIN_HIGH;
		analog_code = 12'h0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("strobe", conversion_strobe, 16'h1);
		check("ext mode", ext_clock_mode, 16'h0);
		conv(8'h8f, 12'ha5c);
		check("ext mode", ext_clock_mode, 16'h1);
		check("strobe release", strobe_oe_n, 16'h1);
		conv(8'h8d, 12'h5a3);
		check("ext mode", ext_clock_mode, 16'h1);
		conv(8'h8e, 12'hfff);
		check("ext mode", ext_clock_mode, 16'h0);
		shutdown_pin <= acpc_pkg::SHUTDOWN_PIN_FLOAT;
		conv(8'h8e, 12'h001);
		conv(8'h8c, 12'h800);
		check("sw pd", sw_power_down, 16'h1);
		conv(8'h8e, 12'h7ff);
		check("sw pd", sw_power_down, 16'h0);
		// A slow conversion gives room to pull shutdown low about a fifth of the way through.
		shutdown_pin <= acpc_pkg::SHUTDOWN_PIN_HIGH;
		fork
			host.frame(8'h8e, 1'b0, rx);
			begin
				repeat (3000) @(posedge clk);
				shutdown_pin <= acpc_pkg::SHUTDOWN_PIN_LOW;
				repeat (8) @(posedge clk);
				check("hw pd", hw_power_down, 16'h1);
				check("converting", converting, 16'h0);
				shutdown_pin <= acpc_pkg::SHUTDOWN_PIN_FLOAT;
			end
		join
		repeat (8) @(posedge clk);
		check("hw pd", hw_power_down, 16'h0);
		for (int i = 0; i < 8; i++) begin
			analog_code <= 12'(i);
			host.frame(8'h8e, 1'b0, rx);
			check("fill strobe", conversion_strobe, 16'h1);
		end
		host.frame(8'h8e, 1'b0, rx);
		check("full strobe", conversion_strobe, 16'h0);
		test_done();
	end
endmodule : tb

bind acpc_control acpc_checker chk (.clk, .reset_n, .shutdown_pin, .conversion_strobe,
	.strobe_oe_n, .hw_power_down, .sw_power_down, .ext_clock_mode, .converting);
